// *** inc/ssp_pkg.sv ***
// shared constants, types and register map of the synchronous serial port
package ssp_pkg;

	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [ADDR_W-1:0] OFF_BUFFER  = 3'h0;
	localparam logic [ADDR_W-1:0] OFF_STATUS  = 3'h1;
	localparam logic [ADDR_W-1:0] OFF_CONTROL = 3'h2;
	localparam logic [ADDR_W-1:0] OFF_RATE    = 3'h3;
	localparam logic [ADDR_W-1:0] OFF_EVENT   = 3'h4;

	// port_control_one fields
	localparam int CTL_WRITE_COLLISION_FLAG    = 7;
	localparam int CTL_OVF     = 6;
	localparam int CTL_EN      = 5;
	localparam int CTL_CKP     = 4;
	localparam int CTL_MODE_HI = 3;
	localparam int CTL_MODE_LO = 0;

	// port_status_reg fields
	localparam int STAT_SMP = 7;
	localparam int STAT_CKE = 6;
	localparam int STAT_BF  = 0;

	localparam logic [DATA_W-1:0] CTL_RESET  = 8'h00;
	localparam logic [DATA_W-1:0] RATE_RESET = 8'h00;

	// port_mode_select codes
	localparam logic [3:0] MODE_SPI_MASTER_LAST = 4'h3;
	localparam logic [3:0] MODE_SPI_SLAVE_SEL   = 4'h4;
	localparam logic [3:0] MODE_SPI_SLAVE_FREE  = 4'h5;
	localparam logic [3:0] MODE_I2C_SLV7        = 4'h6;
	localparam logic [3:0] MODE_I2C_SLV10       = 4'h7;
	localparam logic [3:0] MODE_I2C_MASTER      = 4'h8;
	localparam logic [3:0] MODE_I2C_FW_MASTER   = 4'hB;
	localparam logic [3:0] MODE_I2C_SLV7_SS     = 4'hE;
	localparam logic [3:0] MODE_I2C_SLV10_SS    = 4'hF;

	// shift timing
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] EDGE_LAST     = 4'hF;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_t;

	typedef enum logic [1:0] {
		XS_IDLE  = 2'b01,
		XS_SHIFT = 2'b10
	} xfer_state_t;

	typedef struct packed {
		logic [DATA_W-1:0] ctl;
		logic [1:0]        stat_cfg;
		logic              bf;
		logic              evt;
		logic [DATA_W-1:0] rate;
		logic [DATA_W-1:0] buffer;
		logic [DATA_W-1:0] sr;
		logic              out_bit;
		logic              sck;
		logic [3:0]        edges;
		logic [3:0]        bits;
		xfer_state_t       st;
		logic              clk_prev;
		logic              dat_prev;
		logic              bus_busy;
		logic              tx_mode;
		logic [DATA_W-1:0] rdata;
	} state_t;

	typedef struct packed {
		logic [DATA_W:0] cnt;
	} rate_state_t;

endpackage

// *** rtl/ssp_core.sv ***
// synchronous serial port: spi shifter, i2c control and register file
`timescale 1ns/1ps

// What this block does
// - control bits pick master, polarity, phase, rate
// - shift register moves most significant bit first
// - full byte goes to buffer, sets flags
// - next byte shifts while buffer unread
// - buffer write mid-transfer ignored, collision flag
// - reading the buffer clears buffer-full
// - shift register reached only through buffer
// - i2c master write on busy bus collides
// - i2c slave write while sending collides
// - byte onto full buffer sets overflow flag
// - collision and overflow meaningful per direction
// - enable bit hands pins to the port
// - slave clock release bit stretches clock
// - slave mode codes with address width
// - master clock is clock over four(rate+1)
// - firmware master code keeps slave idle
// - unlisted codes are never i2c modes
module ssp_core (
	input  logic                   CLOCK,
	input  logic                   RESET,
	input  ssp_pkg::reg_req_t      REG_REQ,
	output logic [7:0]             RD_DATA,
	output logic                   PORT_EVENT,
	input  logic                   CLK_PIN_I,
	output logic                   CLK_PIN_O,
	output logic                   CLK_PIN_OE,
	input  logic                   DIN_PIN_I,
	output logic                   DIN_PIN_O,
	output logic                   DIN_PIN_OE,
	output logic                   DOUT_PIN_O,
	output logic                   DOUT_PIN_OE,
	input  logic                   SEL_N
);

	ssp_pkg::state_t s_q;
	ssp_pkg::state_t s_d;

	logic       enabled;
	logic [3:0] mode;
	logic       i2c;
	logic       i2c_master;
	logic       i2c_slave;
	logic       spi_master;
	logic       spi_slave;
	logic       drives_clock;
	logic       pol;
	logic       cpha;
	logic       busy;
	logic       deselected;
	logic       rise;
	logic       fall;
	logic       start_cond;
	logic       stop_cond;
	logic       tick;
	logic       run;
	logic       slave_live;
	logic       lead;
	logic       trail;
	logic       late;
	logic       sample_ev;
	logic       shift_ev;
	logic [7:0] sr_smp;
	logic [3:0] bits_inc;
	logic       done_ev;
	logic       buf_wr;
	logic       buf_rd;
	logic       wr_collide;

	function automatic logic is_i2c_slave(input logic [3:0] m);
		return (m == ssp_pkg::MODE_I2C_SLV7) || (m == ssp_pkg::MODE_I2C_SLV10) ||
			(m == ssp_pkg::MODE_I2C_SLV7_SS) || (m == ssp_pkg::MODE_I2C_SLV10_SS);
	endfunction

	// any code outside the listed set falls back to spi or to nothing
	function automatic logic is_i2c(input logic [3:0] m);
		return is_i2c_slave(m) || (m == ssp_pkg::MODE_I2C_MASTER) ||
			(m == ssp_pkg::MODE_I2C_FW_MASTER);
	endfunction

	assign enabled      = s_q.ctl[ssp_pkg::CTL_EN];
	assign mode         = s_q.ctl[ssp_pkg::CTL_MODE_HI:ssp_pkg::CTL_MODE_LO];
	assign i2c          = is_i2c(mode);
	assign i2c_master   = (mode == ssp_pkg::MODE_I2C_MASTER);
	assign i2c_slave    = is_i2c_slave(mode);
	assign spi_master   = (mode <= ssp_pkg::MODE_SPI_MASTER_LAST);
	assign spi_slave    = (mode == ssp_pkg::MODE_SPI_SLAVE_SEL) ||
		(mode == ssp_pkg::MODE_SPI_SLAVE_FREE);
	assign drives_clock = spi_master || i2c_master;
	// i2c always changes data while scl is low and samples on its rise
	assign pol          = i2c ? 1'b0 : s_q.ctl[ssp_pkg::CTL_CKP];
	assign cpha         = i2c ? 1'b0 : !s_q.stat_cfg[0];
	assign busy         = (s_q.st == ssp_pkg::XS_SHIFT);
	assign deselected   = (mode == ssp_pkg::MODE_SPI_SLAVE_SEL) && SEL_N;

	assign rise       = CLK_PIN_I && !s_q.clk_prev;
	assign fall       = !CLK_PIN_I && s_q.clk_prev;
	assign start_cond = s_q.clk_prev && CLK_PIN_I && s_q.dat_prev && !DIN_PIN_I;
	assign stop_cond  = s_q.clk_prev && CLK_PIN_I && !s_q.dat_prev && DIN_PIN_I;

	assign run = enabled && drives_clock && busy;

	ssp_rate_gen #(
		.W (ssp_pkg::DATA_W)
	) u_rate (
		.CLOCK (CLOCK),
		.RESET (RESET),
		.RUN   (run),
		.RATE  (s_q.rate),
		.TICK  (tick)
	);

	// the spi slave sees the pin unless deselected in select mode; the i2c slave only after a start
	assign slave_live = enabled &&
		((spi_slave && !deselected) || (i2c_slave && s_q.bus_busy));
	assign lead  = drives_clock ? (tick && (s_q.sck == pol))
		: (slave_live && (pol ? fall : rise));
	assign trail = drives_clock ? (tick && (s_q.sck != pol))
		: (slave_live && (pol ? rise : fall));
	assign late      = spi_master && s_q.stat_cfg[1] && !cpha;
	assign sample_ev = (cpha || late) ? trail : lead;
	assign shift_ev  = cpha ? lead : trail;
	assign sr_smp    = {s_q.sr[6:0], DIN_PIN_I};
	assign bits_inc  = s_q.bits + 4'h1;
	assign done_ev   = sample_ev && (bits_inc == ssp_pkg::BITS_PER_BYTE);

	assign buf_wr = REG_REQ.wr && (REG_REQ.addr == ssp_pkg::OFF_BUFFER);
	assign buf_rd = REG_REQ.rd && (REG_REQ.addr == ssp_pkg::OFF_BUFFER);
	// an i2c master may not start while someone else owns the bus
	assign wr_collide = buf_wr && (busy || (i2c_master && s_q.bus_busy));

	always_comb begin
		s_d = s_q;
		s_d.clk_prev = CLK_PIN_I;
		s_d.dat_prev = DIN_PIN_I;

		s_d.rdata = '0;
		if (REG_REQ.rd) begin
			case (REG_REQ.addr)
				ssp_pkg::OFF_BUFFER:  s_d.rdata = s_q.buffer;
				ssp_pkg::OFF_STATUS:  s_d.rdata = {s_q.stat_cfg, 5'h00, s_q.bf};
				ssp_pkg::OFF_CONTROL: s_d.rdata = s_q.ctl;
				ssp_pkg::OFF_RATE:    s_d.rdata = s_q.rate;
				ssp_pkg::OFF_EVENT:   s_d.rdata = {7'h00, s_q.evt};
				default:              s_d.rdata = '0;
			endcase
		end

		// software writes first, so hardware sets below win over clears
		if (REG_REQ.wr) begin
			case (REG_REQ.addr)
				ssp_pkg::OFF_STATUS:  s_d.stat_cfg = REG_REQ.wdata[ssp_pkg::STAT_SMP:
					ssp_pkg::STAT_CKE];
				ssp_pkg::OFF_CONTROL: s_d.ctl = REG_REQ.wdata;
				ssp_pkg::OFF_RATE:    s_d.rate = REG_REQ.wdata;
				ssp_pkg::OFF_EVENT:   s_d.evt = REG_REQ.wdata[0];
				default:              s_d.evt = s_q.evt;
			endcase
		end
		if (buf_rd) begin
			s_d.bf = 1'b0;
		end

		if (start_cond) begin
			s_d.bus_busy = 1'b1;
		end else if (stop_cond) begin
			s_d.bus_busy = 1'b0;
		end

		if (tick) begin
			s_d.sck   = !s_q.sck;
			s_d.edges = s_q.edges + 4'h1;
			if (s_q.edges == ssp_pkg::EDGE_LAST) begin
				s_d.st = ssp_pkg::XS_IDLE;
			end
		end

		if (sample_ev) begin
			s_d.sr   = sr_smp;
			s_d.bits = bits_inc;
			if (!drives_clock) begin
				s_d.st = ssp_pkg::XS_SHIFT;
			end
		end
		if (shift_ev) begin
			s_d.out_bit = sample_ev ? sr_smp[7] : s_q.sr[7];
		end

		if (done_ev) begin
			s_d.bits = '0;
			s_d.evt  = 1'b1;
			if (!drives_clock) begin
				s_d.st      = ssp_pkg::XS_IDLE;
				s_d.tx_mode = 1'b0;
			end
			// a full buffer keeps its byte; the new one is lost
			if (s_q.bf && !buf_rd) begin
				s_d.ctl[ssp_pkg::CTL_OVF] = 1'b1;
			end else begin
				s_d.buffer = sr_smp;
				s_d.bf     = 1'b1;
			end
		end

		if (i2c_slave && (start_cond || stop_cond)) begin
			s_d.bits = '0;
			s_d.st   = ssp_pkg::XS_IDLE;
			if (mode == ssp_pkg::MODE_I2C_SLV7_SS || mode == ssp_pkg::MODE_I2C_SLV10_SS) begin
				s_d.evt = 1'b1;
			end
		end

		if (wr_collide) begin
			s_d.ctl[ssp_pkg::CTL_WRITE_COLLISION_FLAG] = 1'b1;
		end else if (buf_wr) begin
			s_d.buffer  = REG_REQ.wdata;
			s_d.sr      = REG_REQ.wdata;
			s_d.out_bit = REG_REQ.wdata[7];
			s_d.tx_mode = 1'b1;
			if (drives_clock) begin
				s_d.st    = ssp_pkg::XS_SHIFT;
				s_d.edges = '0;
				s_d.sck   = pol;
			end
		end

		if (!enabled || !i2c) begin
			s_d.bus_busy = 1'b0;
		end
		if (!enabled) begin
			s_d.bits    = '0;
			s_d.edges   = '0;
			s_d.st      = ssp_pkg::XS_IDLE;
			s_d.tx_mode = 1'b0;
		end
		if (s_d.st == ssp_pkg::XS_IDLE) begin
			s_d.sck = pol;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			s_q      <= '0;
			s_q.ctl  <= ssp_pkg::CTL_RESET;
			s_q.rate <= ssp_pkg::RATE_RESET;
			s_q.st   <= ssp_pkg::XS_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign RD_DATA    = s_q.rdata;
	assign PORT_EVENT = s_q.evt;
	// clock pin: push-pull for spi master, open drain for i2c
	assign CLK_PIN_O  = i2c ? 1'b0 : s_q.sck;
	assign CLK_PIN_OE = enabled && (i2c ?
		((i2c_master && busy && !s_q.sck) ||
		(i2c_slave && !s_q.ctl[ssp_pkg::CTL_CKP])) : spi_master);
	assign DIN_PIN_O  = 1'b0;
	assign DIN_PIN_OE = enabled && i2c && busy && s_q.tx_mode && !s_q.out_bit;
	assign DOUT_PIN_O  = s_q.out_bit;
	assign DOUT_PIN_OE = enabled && (spi_master || (spi_slave && !deselected));

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RESET);

	a_byte_sets_full: assert property (
		done_ev |=> s_q.bf && s_q.evt) else $error("finished byte did not raise flags");
	a_byte_in_buffer: assert property (
		(done_ev && !s_q.bf) |=> s_q.buffer == $past(sr_smp)) else $error("byte not moved");
	a_collide_ignored: assert property (
		wr_collide |=> s_q.ctl[ssp_pkg::CTL_WRITE_COLLISION_FLAG] && $stable(s_q.buffer) && $stable(s_q.st))
		else $error("colliding write was taken");
	a_collide_sticky: assert property (
		(s_q.ctl[ssp_pkg::CTL_WRITE_COLLISION_FLAG] && !(REG_REQ.wr && REG_REQ.addr == ssp_pkg::OFF_CONTROL))
		|=> s_q.ctl[ssp_pkg::CTL_WRITE_COLLISION_FLAG]) else $error("collision flag cleared by itself");
	a_read_clears_full: assert property (
		(buf_rd && !done_ev) |=> !s_q.bf && (s_q.rdata == $past(s_q.buffer)))
		else $error("buffer read did not clear full flag");
	a_overflow_set: assert property (
		(done_ev && s_q.bf && !buf_rd) |=> s_q.ctl[ssp_pkg::CTL_OVF] && $stable(s_q.buffer))
		else $error("overflow not flagged");
	a_msb_first: assert property (
		(buf_wr && !wr_collide) |=> s_q.out_bit == $past(REG_REQ.wdata[7]))
		else $error("first bit out is not the top bit");
	a_pins_released: assert property (
		!enabled |-> !CLK_PIN_OE && !DIN_PIN_OE && !DOUT_PIN_OE)
		else $error("disabled port drives a pin");
	a_clock_stretch: assert property (
		(enabled && i2c_slave && !s_q.ctl[ssp_pkg::CTL_CKP]) |-> CLK_PIN_OE && !CLK_PIN_O)
		else $error("slave clock not held low");
	a_disabled_idle: assert property (
		!enabled |=> s_q.bits == '0 && s_q.st == ssp_pkg::XS_IDLE)
		else $error("disabled port kept bit count");

	c_spi_master_byte: cover property (done_ev && spi_master);
	c_write_collision: cover property (wr_collide);
	c_i2c_slave_start: cover property (start_cond && i2c_slave);
	c_overflow_byte:   cover property (done_ev && s_q.bf);

endmodule

// *** rtl/ssp_rate_gen.sv ***
// half-period tick generator for the master serial clock
`timescale 1ns/1ps
module ssp_rate_gen #(
	parameter int W = 8
) (
	input  logic         CLOCK,
	input  logic         RESET,
	input  logic         RUN,
	input  logic [W-1:0] RATE,
	output logic         TICK
);

	ssp_pkg::rate_state_t s_q;
	ssp_pkg::rate_state_t s_d;
	logic [W:0]           last;

	// two ticks per serial clock period: clock = CLOCK / (4 * (RATE + 1))
	assign last = {RATE, 1'b1};
	assign TICK = RUN && (s_q.cnt == last);

	always_comb begin
		s_d = s_q;
		if (!RUN || TICK) begin
			s_d.cnt = '0;
		end else begin
			s_d.cnt = s_q.cnt + {{W{1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	a_tick_spacing: assert property (@(posedge CLOCK) disable iff (RESET)
		TICK |=> !TICK) else $error("rate tick came on two adjacent cycles");

endmodule

// *** verification/ssp_peer.sv ***
// serial peer model on the far side of the port pins
`timescale 1ns/1ps
module ssp_peer (
	input  wire logic       sck,
	input  wire logic       sdo,
	input  wire logic       load,
	input  wire logic [7:0] load_byte,
	output logic            sdi,
	output logic [7:0]      rx
);
	logic [7:0] tx = 8'hFF;
	initial sdi = 1'b1;
	initial rx = 8'h00;
	always @(posedge load) begin
		tx = load_byte;
		sdi = load_byte[7];
	end
	always @(posedge sck) rx = {rx[6:0], sdo};
	// spent bits refill inverted so a stale line never passes for data
	always @(negedge sck) begin
		tx = {tx[6:0], ~tx[7]};
		sdi = tx[7];
	end
endmodule

// *** verification/tb_ssp_core.sv ***
// self-checking bench for the synchronous serial port core
`timescale 1ns/1ps
module tb_ssp_core;
	localparam int I2C_RATE = 1;
	localparam int SPI_RATE = 2;
	logic              clk;
	logic              rst;
	ssp_pkg::reg_req_t req;
	logic [7:0]        rd_data;
	logic              port_event;
	logic              clk_o, clk_oe, din_o, din_oe, dout_o, dout_oe;
	logic              sel_n;
	logic              load;
	logic              peer_sdi;
	logic [7:0]        load_byte, peer_rx, v, tx;
	logic [31:0]       seed = 32'hF6A0;
	logic [7:0]        exp_q[$];
	int                error_cnt = 0;
	int                cmp_count = 0;
	wire               clk_wire = clk_oe ? clk_o : 1'b1;
	wire               din_wire = din_oe ? din_o : peer_sdi;

	ssp_core dut (
		.CLOCK(clk), .RESET(rst), .REG_REQ(req), .RD_DATA(rd_data), .PORT_EVENT(port_event),
		.CLK_PIN_I(clk_wire), .CLK_PIN_O(clk_o), .CLK_PIN_OE(clk_oe),
		.DIN_PIN_I(din_wire), .DIN_PIN_O(din_o), .DIN_PIN_OE(din_oe),
		.DOUT_PIN_O(dout_o), .DOUT_PIN_OE(dout_oe), .SEL_N(sel_n));
	ssp_peer peer (.sck(clk_wire), .sdo(dout_o), .load(load), .load_byte(load_byte),
		.sdi(peer_sdi), .rx(peer_rx));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 d = rd_data;
	endtask

	task automatic peer_load(input logic [7:0] b);
		@(posedge clk);
		load_byte <= b;
		load <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
	endtask

	task automatic wait_bf();
		repeat (100) begin
			rd(ssp_pkg::OFF_STATUS, v);
			if (v[ssp_pkg::STAT_BF] === 1'b1)
				break;
		end
		chk("bf_wait", {7'h0, v[ssp_pkg::STAT_BF]}, 8'h01);
		// full rises half a serial clock before the last edge ends the transfer
		repeat (2 * (SPI_RATE + 1)) @(posedge clk);
	endtask

	task automatic start(input logic [7:0] t, input logic [7:0] p);
		peer_load(p);
		wr(ssp_pkg::OFF_BUFFER, t);
		exp_q.push_back(p);
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		complete_run();
	end

	initial begin
		req = '0;
		sel_n = 1'b1;
		load = 1'b0;
		load_byte = 8'h00;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(ssp_pkg::OFF_CONTROL, v);
		chk("control_reset", v, ssp_pkg::CTL_RESET);
		chk("pins_idle", {5'h0, clk_oe, din_oe, dout_oe}, 8'h00);
		wr(3'h5, 8'hAA);
		rd(3'h5, v);
		chk("unmapped", v, 8'h00);
		// master, sample on leading edge, clock idles low
		wr(ssp_pkg::OFF_STATUS, 8'h40);
		wr(ssp_pkg::OFF_RATE, 8'(SPI_RATE));
		wr(ssp_pkg::OFF_CONTROL, 8'h20);
		tx = rnd();
		start(tx, rnd());
		wr(ssp_pkg::OFF_BUFFER, ~tx);
		wait_bf();
		chk("event", {7'h0, port_event}, 8'h01);
		rd(ssp_pkg::OFF_BUFFER, v);
		chk("rx_byte", v, exp_q.pop_front());
		chk("peer_rx", peer_rx, tx);
		rd(ssp_pkg::OFF_STATUS, v);
		chk("bf_clear", v & 8'h01, 8'h00);
		rd(ssp_pkg::OFF_CONTROL, v);
		chk("write_collision_flag", v, 8'hA0);
		wr(ssp_pkg::OFF_CONTROL, 8'h20);
		wr(ssp_pkg::OFF_EVENT, 8'h00);
		// second byte starts before the first is read; the write replaces the unread byte
		start(rnd(), rnd());
		wait_bf();
		tx = rnd();
		start(tx, rnd());
		void'(exp_q.pop_front());
		repeat (20) @(posedge clk);
		rd(ssp_pkg::OFF_BUFFER, v);
		chk("rx_early", v, tx);
		wait_bf();
		rd(ssp_pkg::OFF_BUFFER, v);
		chk("rx_late", v, exp_q.pop_front());
		rd(ssp_pkg::OFF_CONTROL, v);
		chk("no_ovf", v, 8'h20);
		// byte lands while the buffer is still unread
		start(rnd(), rnd());
		wait_bf();
		tx = rnd();
		start(tx, rnd());
		repeat (110) @(posedge clk);
		rd(ssp_pkg::OFF_CONTROL, v);
		chk("ovf", v, 8'h60);
		rd(ssp_pkg::OFF_BUFFER, v);
		chk("ovf_keep", v, tx);
		void'(exp_q.pop_front());
		void'(exp_q.pop_front());
		// abort by disabling, then a whole byte after enabling again
		wr(ssp_pkg::OFF_CONTROL, 8'h20);
		start(rnd(), rnd());
		repeat (30) @(posedge clk);
		wr(ssp_pkg::OFF_CONTROL, 8'h00);
		#1 chk("dis_pins", {5'h0, clk_oe, din_oe, dout_oe}, 8'h00);
		void'(exp_q.pop_front());
		wr(ssp_pkg::OFF_CONTROL, 8'h20);
		start(rnd(), rnd());
		wait_bf();
		rd(ssp_pkg::OFF_BUFFER, v);
		chk("byte_align", v, exp_q.pop_front());
		for (int m = 0; m < 16; m++) begin
			wr(ssp_pkg::OFF_CONTROL, 8'h20 | 8'(m));
			rd(ssp_pkg::OFF_CONTROL, v);
			chk("mode", v, 8'h20 | 8'(m));
			if (m < 5 || m inside {6, 7, 8, 11, 14, 15})
				chk("dout_oe", {7'h0, dout_oe}, m < 4 ? 8'h01 : 8'h00);
			if (m == 4) begin
				// select only once the clock pin has settled high, so no edge is taken
				@(posedge clk);
				sel_n <= 1'b0;
				@(posedge clk);
				#1 chk("sel_oe", {7'h0, dout_oe}, 8'h01);
				@(posedge clk);
				sel_n <= 1'b1;
			end
		end
		wr(ssp_pkg::OFF_CONTROL, 8'h26);
		#1 chk("stretch", {6'h0, clk_oe, clk_o}, 8'h02);
		wr(ssp_pkg::OFF_CONTROL, 8'h36);
		#1 chk("release", {7'h0, clk_oe}, 8'h00);
		// i2c master: one full clock period, then a write mid-byte
		wr(ssp_pkg::OFF_RATE, 8'(I2C_RATE));
		wr(ssp_pkg::OFF_CONTROL, 8'h28);
		peer_load(8'hFF);
		wr(ssp_pkg::OFF_BUFFER, rnd());
		repeat (50) begin
			@(posedge clk);
			if (clk_wire === 1'b0)
				break;
		end
		repeat (50) begin
			@(posedge clk);
			if (clk_wire === 1'b1)
				break;
		end
		v = 8'h00;
		repeat (50) begin
			@(posedge clk);
			v++;
			if (clk_wire === 1'b0)
				break;
		end
		repeat (50) begin
			@(posedge clk);
			v++;
			if (clk_wire === 1'b1)
				break;
		end
		chk("scl_period", v, 8'(4 * (I2C_RATE + 1)));
		wr(ssp_pkg::OFF_BUFFER, 8'h55);
		rd(ssp_pkg::OFF_CONTROL, v);
		chk("i2c_write_collision_flag", v, 8'hA8);
		repeat (100) @(posedge clk);
		complete_run();
	end
endmodule
